/* File: hts_master.sv */
// Purpose: i2c master model standing on the far side of the sensor link
// Assumes: open-drain wire with pull-up, resolved in the bench
// Notes: scl stands high between frames and runs at 125 ns inside them
`timescale 1ns/1ns
module hts_master (
    // link lines
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // data changes only while scl is low
    task automatic clk_bit(input logic b, output logic r);
        sda_o <= b;
        #31 scl_o <= 1'b1;
        #31 r = sda_i;
        #31 scl_o <= 1'b0;
        #32;
    endtask

    task automatic start_cond();
        sda_o <= 1'b1;
        #31 scl_o <= 1'b1;
        #31 sda_o <= 1'b0;
        #31 scl_o <= 1'b0;
        #32;
    endtask

    task automatic stop_cond();
        sda_o <= 1'b0;
        #31 scl_o <= 1'b1;
        #31 sda_o <= 1'b1;
        #63;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(last, r);
    endtask

    task automatic addr_probe(input logic [6:0] a, output logic ack);
        start_cond();
        send_byte({a, 1'b0}, ack);
        stop_cond();
    endtask

    task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({hts_pkg::DEV_ADDR, 1'b0}, a0);
        send_byte(ptr, a1);
        send_byte(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    // pointer, repeated start, read address; every byte but the last acked
    task automatic reg_read(input logic [7:0] ptr, input int n, output logic [7:0] d [6],
            output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({hts_pkg::DEV_ADDR, 1'b0}, a0);
        send_byte(ptr, a1);
        start_cond();
        send_byte({hts_pkg::DEV_ADDR, 1'b1}, a2);
        for (int k = 0; k < n; k++) begin
            recv_byte(k == n - 1, d[k]);
        end
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule

/* File: hts_pkg.sv */
// Purpose: shared constants of the humidity/temperature readout block
// Assumes: 50 MHz system clock, I2C link clocked by SCL
// Notes: register map, control fields, conversion timing, link phases
package hts_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h40;
    localparam logic [7:0] REG_STATE = 8'h00;
    localparam logic [7:0] REG_UPPER = 8'h01;
    localparam logic [7:0] REG_LOWER = 8'h02;
    localparam logic [7:0] REG_CTRL = 8'h03;
    localparam int CTRL_START = 0;
    localparam int CTRL_HEAT = 1;
    localparam int CTRL_TEMP = 4;
    localparam int CTRL_FAST = 5;
    localparam int STATE_BUSY = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int CLK_HZ = 50_000_000;
    localparam int LINK_MAX_KHZ = 400;
    localparam int CONV_NORMAL_MS = 35;
    localparam int CONV_FAST_MS = 18;
    localparam int CONV_NORMAL_CYC = CONV_NORMAL_MS * (CLK_HZ / 1000);
    localparam int CONV_FAST_CYC = CONV_FAST_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 21;
    localparam int HUM_W = 12;
    localparam int TEMP_W = 14;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    typedef enum {P_IDLE, P_ADDR, P_PTR, P_WDATA, P_READ} hts_phase_t;
endpackage

/* File: hts_readout.sv */
// Purpose: I2C slave register file and conversion sequencer of the sensor
// Assumes: SCL_I clocks the link side; converter codes arrive as async pins
// Notes: registers cross to the link side as a toggled snapshot word
`timescale 1ns/1ns

// What this block does
// R1 - answer as I2C slave at seven-bit address 0x40, ignore other addresses
// R2 - link side works with SCL up to 400 kHz; master runs SCL with a 125 ns period (8 MHz), above it
// R3 - writing one to control bit D0 launches a conversion
// R4 - status bit D0 reads low once a result is available
// R5 - result upper byte at 0x01, lower byte at 0x02, upper read first
// R6 - humidity code is 12 bits, left justified, low nibble zero
// R7 - control D0 with D4 set launches a temperature conversion
// R8 - temperature code is 14 bits, left justified, two low bits zero
// R9 - master turns humidity code into percent: divide by 16, minus 24
// R10 - master turns temperature code into Celsius: divide by 32, minus 50
// R11 - normal mode conversion ends 35 ms after launch
// R12 - status high while converting; old result held until completion
// R13 - control D5 selects fast mode: 18 ms, one bit less resolution
// R14 - control D1 switches on the heater element
// R15 - write: address, pointer byte, data byte, each acknowledged, then stop
// R16 - read: pointer, repeated start, read address; acked bytes continue
module hts_readout #(
    parameter int CONV_NORMAL_CYC = hts_pkg::CONV_NORMAL_CYC,
    parameter int CONV_FAST_CYC = hts_pkg::CONV_FAST_CYC
) (
    // system clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // i2c link
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    // converter codes
    input wire logic [hts_pkg::HUM_W-1:0] HUM_CODE_I,
    input wire logic [hts_pkg::TEMP_W-1:0] TEMP_CODE_I,
    // sensor controls
    output logic HEATER_ON_O,
    output logic CONV_BUSY_O
);
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [31:0] w);
        case (p)
            hts_pkg::REG_STATE: rd_byte = w[7:0];
            hts_pkg::REG_UPPER: rd_byte = w[15:8];
            hts_pkg::REG_LOWER: rd_byte = w[23:16];
            hts_pkg::REG_CTRL: rd_byte = w[31:24];
            default: rd_byte = 8'h00;
        endcase
    endfunction

    logic start_tog;
    logic start_seen, next_start_seen;
    hts_pkg::hts_phase_t phase, next_phase;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh, ptr, next_ptr, tx, next_tx;
    logic [7:0] wr_addr, next_wr_addr, wr_data, next_wr_data;
    logic want, next_want, rw, next_rw, wr_tog, next_wr_tog;
    logic pub_seen, next_pub_seen, pub_tog, next_pub_tog;
    logic [31:0] copy, next_copy, snap, next_snap;
    logic [1:0] pub_s;
    logic [7:0] byte_in;
    logic [7:0] rd_now;

    // start condition: sda falls while scl high
    always_ff @(negedge SDA_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            start_tog <= 1'b0;
        end else if (SCL_I) begin
            start_tog <= ~start_tog;
        end
    end

    // sequencing for up to 400 kHz scl [R2]
    always_comb begin
        next_start_seen = start_seen;
        next_phase = phase;
        next_cnt = cnt;
        next_sh = sh;
        next_ptr = ptr;
        next_tx = tx;
        next_want = 1'b0;
        next_rw = rw;
        next_wr_tog = wr_tog;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_copy = copy;
        next_pub_seen = pub_seen;
        byte_in = {sh[6:0], SDA_I};
        rd_now = 8'h00;
        if (pub_s[1] != pub_seen) begin
            next_pub_seen = pub_s[1];
            next_copy = snap;
        end
        if (start_tog != start_seen) begin
            next_start_seen = start_tog;
            next_phase = hts_pkg::P_ADDR;
            next_cnt = 4'h1;
            next_sh = {7'h00, SDA_I};
        end else if (phase != hts_pkg::P_IDLE) begin
            if (cnt != hts_pkg::BIT_ACK) begin
                next_sh = byte_in;
                next_cnt = cnt + 4'h1;
                if (phase == hts_pkg::P_READ) begin
                    if (cnt != hts_pkg::BIT_LAST) begin
                        next_want = ~tx[3'(4'h6 - cnt)];
                    end
                end else if (cnt == hts_pkg::BIT_LAST) begin
                    case (phase)
                        hts_pkg::P_ADDR: begin
                            if (byte_in[7:1] == hts_pkg::DEV_ADDR) begin // [R1]
                                next_want = 1'b1;
                                next_rw = byte_in[0];
                            end else begin
                                next_phase = hts_pkg::P_IDLE;
                            end
                        end
                        hts_pkg::P_PTR: begin
                            next_ptr = byte_in;
                            next_want = 1'b1;
                        end
                        hts_pkg::P_WDATA: begin // [R15]
                            next_wr_addr = ptr;
                            next_wr_data = byte_in;
                            next_wr_tog = ~wr_tog;
                            next_ptr = ptr + 8'h01;
                            next_want = 1'b1;
                        end
                        default: next_phase = hts_pkg::P_IDLE;
                    endcase
                end
            end else begin
                next_cnt = 4'h0;
                case (phase)
                    hts_pkg::P_ADDR: begin
                        if (rw) begin // [R16]
                            rd_now = rd_byte(ptr, copy);
                            next_phase = hts_pkg::P_READ;
                            next_tx = rd_now;
                            next_want = ~rd_now[7];
                        end else begin
                            next_phase = hts_pkg::P_PTR;
                        end
                    end
                    hts_pkg::P_PTR: next_phase = hts_pkg::P_WDATA;
                    hts_pkg::P_READ: begin
                        if (SDA_I) begin
                            next_phase = hts_pkg::P_IDLE;
                        end else begin // upper then lower byte [R5] [R16]
                            rd_now = rd_byte(ptr + 8'h01, copy);
                            next_ptr = ptr + 8'h01;
                            next_tx = rd_now;
                            next_want = ~rd_now[7];
                        end
                    end
                    default: next_phase = phase;
                endcase
            end
        end
    end

    always_ff @(posedge SCL_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            start_seen <= 1'b0;
            phase <= hts_pkg::P_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            tx <= 8'h00;
            want <= 1'b0;
            rw <= 1'b0;
            wr_tog <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            copy <= 32'h0000_0000;
            pub_seen <= 1'b0;
            pub_s <= 2'b00;
        end else begin
            start_seen <= next_start_seen;
            phase <= next_phase;
            cnt <= next_cnt;
            sh <= next_sh;
            ptr <= next_ptr;
            tx <= next_tx;
            want <= next_want;
            rw <= next_rw;
            wr_tog <= next_wr_tog;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            copy <= next_copy;
            pub_seen <= next_pub_seen;
            pub_s <= {pub_s[0], pub_tog};
        end
    end

    // sda changes only while scl is low
    always_ff @(negedge SCL_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SDA_OE_N_O <= 1'b1;
            SDA_O <= 1'b0;
        end else begin
            SDA_OE_N_O <= ~want;
            SDA_O <= 1'b0;
        end
    end

    logic [2:0] wt_s;
    logic wr_seen, next_wr_seen, wr_evt, next_heat;
    logic busy, next_busy, kind, next_kind, fast_run, next_fast_run;
    logic [7:0] ctrl, next_ctrl, upper, next_upper, lower, next_lower;
    logic [hts_pkg::TIMER_W-1:0] timer, next_timer;
    logic [hts_pkg::HUM_W-1:0] hum_s [3];
    logic [hts_pkg::TEMP_W-1:0] temp_s [3];
    logic [15:0] res;

    assign wr_evt = (wt_s[1] == wt_s[2]) && (wt_s[2] != wr_seen);

    always_comb begin
        next_wr_seen = wr_seen;
        next_ctrl = ctrl;
        next_busy = busy;
        next_timer = timer;
        next_kind = kind;
        next_fast_run = fast_run;
        next_upper = upper;
        next_lower = lower;
        res = kind ? {temp_s[2], 2'b00} : {hum_s[2], 4'h0}; // [R6] [R8]
        if (fast_run) begin // [R13]
            res = kind ? {res[15:3], 3'b000} : {res[15:5], 5'h00};
        end
        if (wr_evt) begin
            next_wr_seen = wt_s[2];
            if (wr_addr == hts_pkg::REG_CTRL) begin
                next_ctrl = wr_data;
                if (wr_data[hts_pkg::CTRL_START]) begin // [R3] [R7]
                    next_busy = 1'b1;
                    next_kind = wr_data[hts_pkg::CTRL_TEMP];
                    next_fast_run = wr_data[hts_pkg::CTRL_FAST];
                    next_timer = wr_data[hts_pkg::CTRL_FAST] ?
                        hts_pkg::TIMER_W'(CONV_FAST_CYC) : // [R13]
                        hts_pkg::TIMER_W'(CONV_NORMAL_CYC); // [R11]
                end
            end
        end else if (busy) begin
            if (timer == hts_pkg::TIMER_W'(1)) begin // result only at completion [R12]
                next_busy = 1'b0;
                next_upper = res[15:8];
                next_lower = res[7:0];
                next_ctrl[hts_pkg::CTRL_START] = 1'b0;
            end else begin
                next_timer = timer - hts_pkg::TIMER_W'(1);
            end
        end
        next_heat = next_ctrl[hts_pkg::CTRL_HEAT]; // [R14]
        next_snap = {ctrl, lower, upper, 7'h00, busy}; // [R4] [R12]
        next_pub_tog = pub_tog;
        if (next_snap != snap) begin
            next_pub_tog = ~pub_tog;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wt_s <= 3'b000;
            wr_seen <= 1'b0;
            ctrl <= hts_pkg::CTRL_RESET;
            busy <= 1'b0;
            timer <= '0;
            kind <= 1'b0;
            fast_run <= 1'b0;
            upper <= hts_pkg::DATA_RESET;
            lower <= hts_pkg::DATA_RESET;
            HEATER_ON_O <= 1'b0;
            CONV_BUSY_O <= 1'b0;
            snap <= 32'h0000_0000;
            pub_tog <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                hum_s[i] <= '0;
                temp_s[i] <= '0;
            end
        end else begin
            wt_s <= {wt_s[1:0], wr_tog};
            wr_seen <= next_wr_seen;
            ctrl <= next_ctrl;
            busy <= next_busy;
            timer <= next_timer;
            kind <= next_kind;
            fast_run <= next_fast_run;
            upper <= next_upper;
            lower <= next_lower;
            HEATER_ON_O <= next_heat;
            CONV_BUSY_O <= next_busy;
            snap <= next_snap;
            pub_tog <= next_pub_tog;
            hum_s[0] <= HUM_CODE_I;
            temp_s[0] <= TEMP_CODE_I;
            for (int i = 1; i < 3; i++) begin
                hum_s[i] <= hum_s[i-1];
                temp_s[i] <= temp_s[i-1];
            end
        end
    end

    addr_match_a: assert property (@(posedge SCL_I) disable iff (SYS_RST_I) // [R1]
        (start_tog == start_seen && phase == hts_pkg::P_ADDR && cnt == hts_pkg::BIT_LAST
         && sh[6:0] != hts_pkg::DEV_ADDR[6:0]) |=> !want && phase == hts_pkg::P_IDLE)
        else $error("foreign address acknowledged");
    conv_start_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R3]
        (wr_evt && wr_addr == hts_pkg::REG_CTRL && wr_data[hts_pkg::CTRL_START])
        |=> busy && kind == $past(wr_data[hts_pkg::CTRL_TEMP]))
        else $error("start write did not launch conversion");
    ready_low_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R4]
        $fell(busy) |=> !snap[hts_pkg::STATE_BUSY] ##1 !snap[hts_pkg::STATE_BUSY])
        else $error("ready flag not low after completion");
    hum_format_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R6]
        ($fell(busy) && !kind) |-> lower[3:0] == 4'h0 && upper == hum_s[2][11:4])
        else $error("humidity result misaligned");
    temp_format_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R8]
        ($fell(busy) && kind) |-> lower[1:0] == 2'b00 && upper == temp_s[2][13:6])
        else $error("temperature result misaligned");
    conv_time_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R11]
        ($rose(busy) && !fast_run) |-> timer == hts_pkg::TIMER_W'(CONV_NORMAL_CYC))
        else $error("normal conversion time wrong");
    fast_mode_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R13]
        ($rose(busy) && fast_run) |-> timer == hts_pkg::TIMER_W'(CONV_FAST_CYC))
        else $error("fast conversion time wrong");
    hold_result_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R12]
        (busy && $past(busy)) |-> $stable(upper) && $stable(lower) && CONV_BUSY_O)
        else $error("result changed during conversion");
    heater_on_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // [R14]
        $changed(ctrl[hts_pkg::CTRL_HEAT]) |-> HEATER_ON_O == ctrl[hts_pkg::CTRL_HEAT])
        else $error("heater does not follow control");
endmodule

/* File: hts_readout_test.sv */
// Purpose: self-checking bench of the sensor readout through its i2c port
// Assumes: short conversion counts so each conversion takes microseconds
// Notes: each mode is launched, polled and read back; codes have odd lsb
`timescale 1ns/1ns
module hts_readout_test;
    localparam int N_NORM = 2000;
    localparam int N_FAST = 1000;
    localparam logic [11:0] HUM = 12'hABD;
    localparam logic [13:0] TMP = 14'h2ABF;
    localparam logic [7:0] MODE [4] = '{8'h01, 8'h11, 8'h21, 8'h31};
    logic clk, rst, scl, sda_m, sda, sda_q, sda_oe_n, heat, busy, ok;
    logic [11:0] hum;
    logic [13:0] tmp;
    logic [7:0] rd [6];
    logic [7:0] ctrl;
    logic [15:0] exp_w, prev;
    int err_total, checks, run, k;

    assign sda = sda_m & (sda_oe_n | sda_q);

    hts_readout #(.CONV_NORMAL_CYC(N_NORM), .CONV_FAST_CYC(N_FAST)) u_dut (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_q),
        .SDA_OE_N_O(sda_oe_n), .HUM_CODE_I(hum), .TEMP_CODE_I(tmp),
        .HEATER_ON_O(heat), .CONV_BUSY_O(busy));

    hts_master u_mst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (busy === 1'b1) run <= run + 1;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    initial begin
        #1_500_000;
        err_total++;
        $display("wrong value at %0t: run did not finish", $time);
        stop_test();
    end

    initial begin
        rst = 1'b1;
        hum = HUM;
        tmp = TMP;
        err_total = 0;
        checks = 0;
        run = 0;
        prev = 16'h0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #5;
        chk(heat, 16'h0000, "heater after reset");
        chk(busy, 16'h0000, "busy after reset");
        u_mst.reg_read(hts_pkg::REG_STATE, 5, rd, ok);
        chk(ok, 16'h0001, "read ack");
        for (k = 0; k < 5; k++) chk(rd[k], 16'h0000, "reset value or unmapped");
        u_mst.addr_probe(7'h41, ok);
        chk(ok, 16'h0000, "foreign address acked");
        u_mst.reg_write(hts_pkg::REG_CTRL, 8'h02, ok);
        chk(ok, 16'h0001, "write ack");
        repeat (8) @(posedge clk);
        #5;
        chk(heat, 16'h0001, "heater on");
        chk(busy, 16'h0000, "busy without start");
        u_mst.reg_write(hts_pkg::REG_UPPER, 8'h55, ok);
        u_mst.reg_read(hts_pkg::REG_UPPER, 1, rd, ok);
        chk(rd[0], 16'h0000, "read-only upper byte written");
        for (int m = 0; m < 4; m++) begin
            ctrl = MODE[m];
            if (ctrl[hts_pkg::CTRL_TEMP])
                exp_w = {TMP[13:1], TMP[0] & ~ctrl[5], 2'b00};
            else
                exp_w = {HUM[11:1], HUM[0] & ~ctrl[5], 4'h0};
            run = 0;
            u_mst.reg_write(hts_pkg::REG_CTRL, ctrl, ok);
            u_mst.reg_read(hts_pkg::REG_STATE, 3, rd, ok);
            chk(rd[0][0], 16'h0001, "status while converting");
            chk({rd[1], rd[2]}, prev, "result held while converting");
            for (k = 0; k < 40 && rd[0][0] !== 1'b0; k++) begin
                u_mst.reg_read(hts_pkg::REG_STATE, 1, rd, ok);
            end
            if (k == 40) begin
                err_total++;
                $display("wrong value at %0t: status never cleared", $time);
                stop_test();
            end
            chk(run[15:0], ctrl[5] ? N_FAST : N_NORM, "conversion length");
            u_mst.reg_read(hts_pkg::REG_UPPER, 2, rd, ok);
            chk({rd[0], rd[1]}, exp_w, "result word");
            if (ctrl[hts_pkg::CTRL_TEMP])
                chk(16'(({rd[0], rd[1]} >> 2) / 32 - 50), 16'(exp_w[15:2] / 32 - 50), "celsius");
            else
                chk(16'(({rd[0], rd[1]} >> 4) / 16 - 24), 16'(exp_w[15:4] / 16 - 24), "percent");
            u_mst.reg_read(hts_pkg::REG_CTRL, 1, rd, ok);
            chk(rd[0], ctrl & 8'hFE, "control readback");
            prev = exp_w;
        end
        chk(heat, 16'h0000, "heater off");
        stop_test();
    end
endmodule
